// *** uarr_consts.vh ***
// Register map, field positions, reset values and sampling constants of the serial receiver.
`ifndef UARR_CONSTS_VH
`define UARR_CONSTS_VH

// Register byte offsets on the APB bus.
`define UARR_OFF_DATA 12'h000
`define UARR_OFF_STATUS 12'h004
`define UARR_OFF_CTRL 12'h008
`define UARR_OFF_DIV 12'h00c

// Control register fields.
`define UARR_CTRL_EN_BIT 0
`define UARR_CTRL_DS_BIT 1
`define UARR_CTRL_LEN_LSB 4
`define UARR_CTRL_LEN_MSB 7
`define UARR_CTRL_RESET 8'h80

// Status register fields.
`define UARR_ST_COMPLETE_BIT 0
`define UARR_ST_FRAME_ERR_BIT 1
`define UARR_ST_OVERRUN_BIT 2
`define UARR_ST_BUSY_BIT 3

// Sample tick divisor reset value.
`define UARR_DIV_RESET 12'h033

// Oversampling factors and first voting sample in both modes.
`define UARR_OS_NORMAL 5'h10
`define UARR_OS_DOUBLE 5'h08
`define UARR_SF_NORMAL 5'h08
`define UARR_SF_DOUBLE 5'h04

// Allowed data plus parity length of one frame.
`define UARR_LEN_MIN 4'h5
`define UARR_LEN_MAX 4'ha
`define UARR_DATA_W 10

`endif

// *** uarr_buffer.v ***
// Small first-in first-out buffer with valid and ready on both sides and a flush input.
`timescale 1ns/100ps
`default_nettype none

module uarr_buffer #(
   parameter WIDTH = 11,
   parameter DEPTH = 2,
   parameter AW = 1
) (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Discards every stored word.
   input wire flush,
   // Filling side.
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Draining side.
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // Advances a pointer with wrap at the configured depth.
   function [AW-1:0] ptr_next;
      input [AW-1:0] p;
      begin
         if (p == DEPTH[AW-1:0] - 1'b1) begin
            ptr_next = {AW{1'b0}};
         end else begin
            ptr_next = p + 1'b1;
         end
      end
   endfunction

   assign in_ready = (count < DEPTH[AW:0]) && !flush;
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready && !flush;

   // Storage array; only written words are ever read, so it needs no reset.
   always @(posedge pclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill level; a flush wins over any push or pop.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (flush) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= ptr_next(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= ptr_next(rd_ptr);
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// *** uarr_receiver.v ***
// Asynchronous serial receiver with start detection, majority voting and an APB register file.
`timescale 1ns/100ps
`default_nettype none
`include "uarr_consts.vh"

module uarr_receiver #(
   parameter DIV_W = 12,
   parameter BUF_DEPTH = 2
) (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Serial line from the remote transmitter.
   input wire serial_input_pin
);

   localparam DW = `UARR_DATA_W;
   localparam WW = DW + 1;

   // Recovery states. Idle hunts for a falling edge, start judges the
   // start bit votes, bits shifts the character in and stop judges the
   // first stop bit only.
   localparam ST_IDLE = 2'b00;
   localparam ST_START = 2'b01;
   localparam ST_BITS = 2'b10;
   localparam ST_STOP = 2'b11;

   // Configuration registers.
   reg [7:0] control_status_a;
   reg [DIV_W-1:0] divisor;

   // Recovery state. Inside a frame smp_cnt names the sample that the
   // next tick takes, so compares against it name the sample in hand.
   reg [1:0] state;
   reg [4:0] smp_cnt;
   reg [3:0] bit_idx;
   // The two earlier centre samples; the pin itself is the third vote.
   reg [1:0] votes;
   reg [DW-1:0] shreg;
   reg last_smp;
   reg [DIV_W-1:0] tick_cnt;

   // Word waiting to enter the buffer, and the overrun flag.
   reg pend_valid;
   reg [WW-1:0] pend_word;
   reg overrun;

   // Decoded controls and sampling positions.
   wire receiver_enable_bit;
   wire double_speed_select;
   wire [3:0] len_raw;
   wire [3:0] frame_len;
   wire [4:0] os;
   wire [4:0] sf;
   wire [4:0] sl;
   wire tick;
   wire in_vote;
   wire vote;
   wire [DW-1:0] aligned;

   // Buffer connections.
   wire buf_in_ready;
   wire buf_out_valid;
   wire buf_out_ready;
   wire [WW-1:0] buf_out_data;

   // Bus phase decode. The setup cycle captures read data one edge early.
   // It also keeps the pop at the access edge from racing the capture.
   wire setup_phase;
   wire access_phase;
   wire mapped;
   wire rd_data_access;

   // Majority of three samples: one when two or three are high.
   function maj3;
      input [2:0] s;
      begin
         maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
      end
   endfunction

   // Clamps the programmed frame length into the supported range.
   // A length outside five to ten would misalign the character, so it
   // is pulled to the nearer end.
   function [3:0] clamp_len;
      input [3:0] l;
      begin
         if (l < `UARR_LEN_MIN) begin
            clamp_len = `UARR_LEN_MIN;
         end else if (l > `UARR_LEN_MAX) begin
            clamp_len = `UARR_LEN_MAX;
         end else begin
            clamp_len = l;
         end
      end
   endfunction

   assign receiver_enable_bit = control_status_a[`UARR_CTRL_EN_BIT];
   assign double_speed_select = control_status_a[`UARR_CTRL_DS_BIT];
   assign len_raw = control_status_a[`UARR_CTRL_LEN_MSB:`UARR_CTRL_LEN_LSB];
   assign frame_len = clamp_len(len_raw);

   // Sample window per mode; the voting samples are sf, sf+1 and sf+2.
   assign os = double_speed_select ? `UARR_OS_DOUBLE : `UARR_OS_NORMAL;
   assign sf = double_speed_select ? `UARR_SF_DOUBLE : `UARR_SF_NORMAL;
   assign sl = sf + 5'h02;
   assign in_vote = (smp_cnt >= sf) && (smp_cnt <= sl);
   assign vote = maj3({votes, serial_input_pin});

   // Shift register fills from the top, so short frames are moved down.
   // Older bits below the character fall off in the shift, so no clear is needed.
   assign aligned = shreg >> (4'ha - frame_len);

   // Sample tick: one pulse every divisor+1 clocks, only while enabled.
   // The compare is not an equality, so a smaller divisor written while
   // the count is above it gives a tick at once instead of a long wrap.
   assign tick = receiver_enable_bit && (tick_cnt >= divisor);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= {DIV_W{1'b0}};
      end else if (!receiver_enable_bit || tick) begin
         tick_cnt <= {DIV_W{1'b0}};
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   // Clock and data recovery. Control bits are used live, so software
   // should change mode or length only while the receiver is idle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         smp_cnt <= 5'h00;
         bit_idx <= 4'h0;
         votes <= 2'b00;
         shreg <= {DW{1'b0}};
         last_smp <= 1'b1;
      end else if (!receiver_enable_bit) begin
         // Idle with the line taken as high, so a line already low at enable is seen as an edge.
         state <= ST_IDLE;
         smp_cnt <= 5'h00;
         bit_idx <= 4'h0;
         votes <= 2'b00;
         last_smp <= 1'b1;
      end else if (tick) begin
         last_smp <= serial_input_pin;
         if (in_vote) begin
            votes <= {votes[0], serial_input_pin};
         end
         case (state)
            ST_IDLE: begin
               // A high sample followed by a low one is sample one, so
               // the next tick takes sample two. Counting from one here
               // would put every vote a sample late.
               if (last_smp && !serial_input_pin) begin
                  state <= ST_START;
                  smp_cnt <= 5'h02;
               end
            end
            ST_START: begin
               smp_cnt <= smp_cnt + 5'h01;
               if (smp_cnt == sl && vote) begin
                  // Mostly high votes: a spike, look for the next edge.
                  state <= ST_IDLE;
                  smp_cnt <= 5'h00;
               end else if (smp_cnt == os) begin
                  // The start bit now sets the phase of every later bit.
                  state <= ST_BITS;
                  smp_cnt <= 5'h01;
                  bit_idx <= 4'h0;
               end
            end
            ST_BITS: begin
               smp_cnt <= smp_cnt + 5'h01;
               if (smp_cnt == sl) begin
                  shreg <= {vote, shreg[DW-1:1]};
               end
               if (smp_cnt == os) begin
                  smp_cnt <= 5'h01;
                  if (bit_idx == frame_len - 4'h1) begin
                     state <= ST_STOP;
                  end else begin
                     bit_idx <= bit_idx + 4'h1;
                  end
               end
            end
            ST_STOP: begin
               smp_cnt <= smp_cnt + 5'h01;
               // Normal mode rearms on the last vote; double speed one
               // sample later. Further stop bits just look like idle line.
               if (smp_cnt == sl && !double_speed_select) begin
                  state <= ST_IDLE;
                  smp_cnt <= 5'h00;
               end else if (smp_cnt == sl + 5'h01) begin
                  state <= ST_IDLE;
                  smp_cnt <= 5'h00;
               end
            end
            default: begin
               state <= ST_IDLE;
               smp_cnt <= 5'h00;
            end
         endcase
      end
   end

   // Finished frames wait here for the buffer. A frame that completes
   // while the previous one is still refused is dropped and flagged.
   // Overrun clears when a waiting word finally enters the buffer or the receiver is disabled.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_valid <= 1'b0;
         pend_word <= {WW{1'b0}};
         overrun <= 1'b0;
      end else if (!receiver_enable_bit) begin
         pend_valid <= 1'b0;
         overrun <= 1'b0;
      end else begin
         if (tick && state == ST_STOP && smp_cnt == sl) begin
            if (pend_valid && !buf_in_ready) begin
               overrun <= 1'b1;
            end else begin
               pend_valid <= 1'b1;
               // The frame error bit travels with its character.
               pend_word <= {~vote, aligned};
            end
         end else if (pend_valid && buf_in_ready) begin
            pend_valid <= 1'b0;
            overrun <= 1'b0;
         end
      end
   end

   // Two-entry buffer holds received characters until software reads them.
   // A flush also rewinds both pointers, so a re-enabled receiver starts empty.
   uarr_buffer #(
      .WIDTH(WW),
      .DEPTH(BUF_DEPTH),
      .AW(1)
   ) u_buffer (
      .pclk(pclk),
      .presetn(presetn),
      .flush(!receiver_enable_bit),
      .in_valid(pend_valid),
      .in_ready(buf_in_ready),
      .in_data(pend_word),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // APB decode; every access completes without wait states.
   // With ready tied high the access phase is always one cycle long.
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign mapped = (paddr == `UARR_OFF_DATA) || (paddr == `UARR_OFF_STATUS) ||
                   (paddr == `UARR_OFF_CTRL) || (paddr == `UARR_OFF_DIV);
   assign pready = 1'b1;
   assign pslverr = access_phase && !mapped;
   assign rd_data_access = access_phase && !pwrite && (paddr == `UARR_OFF_DATA);

   // Each data read removes the head character.
   assign buf_out_ready = rd_data_access;

   // Writable registers take effect at the access edge.
   // Writes to the data and status offsets are accepted and ignored.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_status_a <= `UARR_CTRL_RESET;
         divisor <= `UARR_DIV_RESET;
      end else if (access_phase && pwrite) begin
         if (paddr == `UARR_OFF_CTRL) begin
            control_status_a <= pwdata[7:0];
         end
         if (paddr == `UARR_OFF_DIV) begin
            divisor <= pwdata[DIV_W-1:0];
         end
      end
   end

   // Read data is captured in the setup cycle and held through the access.
   // The head character cannot leave before the access edge, so the word
   // and its status match.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            `UARR_OFF_DATA: begin
               if (buf_out_valid) begin
                  prdata[DW-1:0] <= buf_out_data[DW-1:0];
               end
            end
            `UARR_OFF_STATUS: begin
               prdata[`UARR_ST_COMPLETE_BIT] <= buf_out_valid;
               prdata[`UARR_ST_FRAME_ERR_BIT] <= buf_out_valid && buf_out_data[DW];
               prdata[`UARR_ST_OVERRUN_BIT] <= overrun;
               prdata[`UARR_ST_BUSY_BIT] <= (state != ST_IDLE);
            end
            `UARR_OFF_CTRL: begin
               prdata[7:0] <= control_status_a;
            end
            `UARR_OFF_DIV: begin
               prdata[DIV_W-1:0] <= divisor;
            end
            default: begin
               prdata <= 32'h0000_0000;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** uarr_chk.sv ***
// Concurrent checks on the serial receiver's register port, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
`include "uarr_consts.vh"
module uarr_chk (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Register port.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Serial line.
   input wire serial_input_pin
);
   logic acc;
   logic rd;
   logic mapped;
   logic sh_en;
   logic sh_ds;
   logic [1:0] dis_cnt;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Access phase decode shared by the properties.
   assign acc = psel && penable;
   assign rd = acc && !pwrite;
   assign mapped = paddr == `UARR_OFF_DATA || paddr == `UARR_OFF_STATUS ||
      paddr == `UARR_OFF_CTRL || paddr == `UARR_OFF_DIV;
   // Shadow of the control bits; the flush is given a few cycles to settle before judging.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_en <= 1'b0;
         sh_ds <= 1'b0;
         dis_cnt <= 2'h0;
      end else begin
         if (acc && pwrite && paddr == `UARR_OFF_CTRL) begin
            sh_en <= pwdata[0];
            sh_ds <= pwdata[1];
         end
         dis_cnt <= sh_en ? 2'h0 : (dis_cnt == 2'h3 ? dis_cnt : dis_cnt + 2'h1);
      end
   end
   a_ready_access: assert property (acc |-> pready)
      else $error("access phase without ready");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_unmapped_zero: assert property (rd && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_width: assert property (rd && paddr == `UARR_OFF_STATUS |-> prdata[31:4] == 28'h0)
      else $error("status upper bits set");
   a_data_width: assert property (rd && paddr == `UARR_OFF_DATA |-> prdata[31:10] == 22'h0)
      else $error("character wider than ten bits");
   a_ctrl_back: assert property (rd && paddr == `UARR_OFF_CTRL |->
      prdata[1:0] == {sh_ds, sh_en} && prdata[31:8] == 24'h0)
      else $error("control readback differs");
   a_disabled_empty: assert property (rd && paddr == `UARR_OFF_STATUS && dis_cnt == 2'h3 |->
      !prdata[0] && !prdata[3])
      else $error("disabled receiver not idle and empty");
   c_char_seen: cover property (rd && paddr == `UARR_OFF_STATUS && prdata[0]);
   c_frame_err: cover property (rd && paddr == `UARR_OFF_STATUS && prdata[1]);
   c_overrun: cover property (rd && paddr == `UARR_OFF_STATUS && prdata[2]);
   c_refused: cover property (acc && pslverr);
endmodule
bind uarr_receiver uarr_chk u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .serial_input_pin
);
`default_nettype wire

// *** uarr_tx_model.sv ***
// Behavioural remote transmitter that drives the receive line.
`timescale 1ns/100ps
`default_nettype none
module uarr_tx_model (
   // Clock that paces the bit timing.
   input wire logic pclk,
   // Serial line, idle high.
   output var logic line
);
   initial line = 1'b1;
   // Holds one level for a number of clocks; the caller picks the bit rate.
   task automatic hold(input logic b, input int n);
      line <= b;
      repeat (n) @(posedge pclk);
   endtask
   // Start bit, data bits lowest first, then one stop bit of chosen level and length.
   task automatic send(input logic [9:0] d, input int len, input int bc, input logic stop,
         input int sc);
      hold(1'b0, bc);
      for (int i = 0; i < len; i++) hold(d[i], bc);
      hold(stop, sc);
      // A low stop leaves the line low, so idle high is restored before returning.
      if (!stop) hold(1'b1, bc);
   endtask
endmodule
`default_nettype wire

// *** tb_uart_async_receiver_recovery.sv ***
// Self-checking testbench for the serial receiver.
`timescale 1ns/100ps
`default_nettype none
`include "uarr_consts.vh"
module tb_uart_async_receiver_recovery;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic line;
   int fail_count = 0;
   int checked = 0;
   uarr_receiver u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .serial_input_pin(line));
   uarr_tx_model u_tx (.pclk, .line);
   // Free-running system clock.
   always #5 pclk = ~pclk;
   task automatic tally_and_finish;
      if (fail_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic give_up(input string what);
      chk(what, 32'h1, 32'h0);
      tally_and_finish;
   endtask
   // One transfer; an idle cycle follows so the next setup never lands in the same step.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] q, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) give_up("ready wait");
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      bus(1'b1, a, d, q, e);
   endtask
   task automatic reg_rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      bus(1'b0, a, 32'h0, q, e);
   endtask
   task automatic cfg(input logic [3:0] len, input logic ds);
      reg_wr(`UARR_OFF_CTRL, {24'h0, len, 2'b00, ds, 1'b1});
   endtask
   task automatic sc_reset;
      logic [31:0] d;
      logic e;
      reg_rd(`UARR_OFF_CTRL, d);
      chk("control reset", {24'h0, `UARR_CTRL_RESET}, d);
      reg_rd(`UARR_OFF_DIV, d);
      chk("divisor reset", {20'h0, `UARR_DIV_RESET}, d);
      reg_rd(`UARR_OFF_STATUS, d);
      chk("status reset", 32'h0, d);
      bus(1'b0, 12'h010, 32'h0, d, e);
      chk("unmapped refusal", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, d);
   endtask
   // Every length in both speeds; normal speed bits run a clock fast, exact or slow.
   task automatic sc_frames;
      logic [31:0] d;
      logic [9:0] v;
      int bc;
      reg_wr(`UARR_OFF_DIV, 32'h3);
      for (int ds = 0; ds < 2; ds++) begin
         for (int len = 5; len <= 10; len++) begin
            v = 10'h2b5 + 10'(len * 37);
            bc = ds ? 32 : 63 + len % 3;
            cfg(len[3:0], ds[0]);
            u_tx.send(v, len, bc, 1'b1, bc);
            reg_rd(`UARR_OFF_STATUS, d);
            chk("status after frame", 32'h1, d & 32'hf);
            reg_rd(`UARR_OFF_DATA, d);
            chk("character", {22'h0, v & (10'h3ff >> (10 - len))}, d);
            reg_rd(`UARR_OFF_STATUS, d);
            chk("status drained", 32'h0, d & 32'h1);
         end
      end
   endtask
   // A short stop followed at once by a frame whose stop is low.
   task automatic sc_errors;
      logic [31:0] d;
      cfg(4'h8, 1'b0);
      u_tx.send(10'h03c, 8, 64, 1'b1, 48);
      u_tx.send(10'h0c3, 8, 64, 1'b0, 64);
      reg_rd(`UARR_OFF_STATUS, d);
      chk("good head status", 32'h1, d & 32'h3);
      reg_rd(`UARR_OFF_DATA, d);
      chk("first character", 32'h03c, d);
      reg_rd(`UARR_OFF_STATUS, d);
      chk("frame error status", 32'h3, d & 32'h3);
      reg_rd(`UARR_OFF_DATA, d);
      chk("errored character", 32'h0c3, d);
   endtask
   // A low spike shorter than the start votes, then a real frame, then a
   // pulse low through sample nine, which wins the start vote two to one.
   task automatic sc_noise;
      logic [31:0] d;
      u_tx.hold(1'b0, 20);
      u_tx.hold(1'b1, 200);
      reg_rd(`UARR_OFF_STATUS, d);
      chk("spike rejected", 32'h0, d & 32'h9);
      u_tx.send(10'h05a, 8, 64, 1'b1, 64);
      reg_rd(`UARR_OFF_DATA, d);
      chk("character after spike", 32'h05a, d);
      u_tx.hold(1'b0, 36);
      u_tx.hold(1'b1, 640);
      reg_rd(`UARR_OFF_DATA, d);
      chk("start vote window", 32'h0ff, d);
   endtask
   // Fill past capacity, drain by polling, then flush by disabling.
   task automatic sc_buffer;
      logic [31:0] d;
      int n;
      for (int i = 1; i <= 4; i++) u_tx.send(10'(i * 17), 8, 64, 1'b1, 64);
      reg_rd(`UARR_OFF_STATUS, d);
      chk("overrun status", 32'h5, d & 32'h5);
      n = 0;
      while (d[0] === 1'b1 && n < 8) begin
         reg_rd(`UARR_OFF_DATA, d);
         n++;
         chk("drained character", 32'(n * 17), d);
         reg_rd(`UARR_OFF_STATUS, d);
      end
      chk("drain count", 32'h3, 32'(n));
      u_tx.send(10'h011, 8, 64, 1'b1, 64);
      u_tx.send(10'h022, 8, 64, 1'b1, 64);
      reg_wr(`UARR_OFF_CTRL, 32'h0);
      reg_rd(`UARR_OFF_STATUS, d);
      reg_rd(`UARR_OFF_STATUS, d);
      chk("flushed status", 32'h0, d & 32'h9);
      cfg(4'h8, 1'b0);
      reg_rd(`UARR_OFF_STATUS, d);
      chk("empty after enable", 32'h0, d & 32'h1);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      sc_reset;
      sc_frames;
      sc_errors;
      sc_noise;
      sc_buffer;
      tally_and_finish;
   end
   // Cuts a hang short.
   initial begin
      repeat (100000) @(posedge pclk);
      give_up("run length");
   end
endmodule
`default_nettype wire
